// *** aec16_consts.vh ***
// constants for the dual 8-bit asynchronous event counter
// assumes a 32-bit axi4-lite slave with word-indexed registers
`ifndef AEC16_CONSTS_VH
`define AEC16_CONSTS_VH

// register indexes, byte address is four times the index
`define AEC16_IDX_EDGE     16'hff92
`define AEC16_IDX_CLKSEL   16'hff94
`define AEC16_IDX_CTRL     16'hff95
`define AEC16_IDX_UPPER    16'hff96
`define AEC16_IDX_LOWER    16'hff97
`define AEC16_IDX_IRQEN    16'hfff4
`define AEC16_IDX_IRQFLAG  16'hfff7

// input_edge_select fields
`define AEC16_EDGE_PWM_BIT   0
`define AEC16_EDGE_LO_LSB    4
`define AEC16_EDGE_HI_LSB    6
`define AEC16_EDGE_MASK      8'hf1

// counter_clock_select fields
`define AEC16_CLK_LO_LSB     0
`define AEC16_CLK_HI_LSB     2
`define AEC16_CLK_MASK       8'h0f

// counter_control_status fields
`define AEC16_CTRL_OVF_BIT   7
`define AEC16_CTRL_CH_BIT    4
`define AEC16_CTRL_UPPER_COUNT_ENABLE_BIT  3
`define AEC16_CTRL_LOWER_COUNT_ENABLE_BIT  2
`define AEC16_CTRL_UPPER_RESET_CONTROL_BIT  1
`define AEC16_CTRL_LOWER_RESET_CONTROL_BIT  0
`define AEC16_CTRL_MASK      8'h1f

// edge select encodings
`define AEC16_EDGE_FALL      2'h0
`define AEC16_EDGE_RISE      2'h1

// clock select encodings
`define AEC16_CLK_PIN        2'h0
`define AEC16_CLK_DIV2       2'h1
`define AEC16_CLK_DIV4       2'h2
`define AEC16_CLK_DIV8       2'h3

// reset values
`define AEC16_RST_BYTE       8'h00

// axi responses
`define AEC16_RESP_OKAY      2'h0
`define AEC16_RESP_SLVERR    2'h2

`endif

// *** aec16_sync.v ***
// three-stage pin synchroniser with a debounced level and edge pulses
// assumes pin_i is asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module aec16_sync
(
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire pin_i,
  output reg  level_o,
  output reg  rise_o,
  output reg  fall_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      level_o <= 1'b1;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end
    else
    begin
      s1_reg  <= pin_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
      if ((s2_reg == s3_reg) && (s3_reg != level_o))
      begin
        level_o <= s3_reg;
        rise_o  <= s3_reg;
        fall_o  <= ~s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** aec16_counter.v ***
// dual 8-bit event counter, chainable to 16 bits, with axi4-lite registers
// assumes event pins are asynchronous; bus runs on mclk_i
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "aec16_consts.vh"

// Function
// - edge select 00 counts falling edges of the low event pin
// - pwm enable zero halts pwm and selects the event gate pin
// - low clock select 00 clocks the lower counter from its pin
// - upper overflow flag bit 7 sets when upper rolls ff to 00
// - flag clears only by writing zero after reading one
// - channel bit 4 zero chains both counters into one 16-bit counter
// - upper counter counts only while its enable bit 3 is one
// - lower counter counts only while its enable bit 2 is one
// - upper reset-control one releases the upper counter
// - lower reset-control one releases the lower counter
// - upper counter is a read-only 8-bit up-counter, alone or chained
// - standalone upper clock: own pin or system clock over 2, 4, 8
// - software can clear the upper counter to zero
// - in 16-bit mode lower overflow clocks the upper counter
// - lower counter is a read-only 8-bit up-counter, the low byte
// - irq flag sets on upper overflow, clears when software writes zero
// - irq request reaches the processor only while its enable is one
module aec16_counter
#(
  parameter ADDR_W = 20
)
(
  input  wire              mclk_i,
  input  wire              rst_b_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output reg  [1:0]        s_axi_bresp_o,
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  input  wire              low_event_input_pin_i,
  input  wire              high_event_input_pin_i,
  input  wire              event_gate_irq_pin_i,
  output wire              counter_irq_o,
  output reg               counter_pwm_o
);
  // register index match on a byte address
  function hit;
    input [ADDR_W-1:0] addr;
    input [15:0]       idx;
    begin
      hit = (addr[ADDR_W-1:2] == {{(ADDR_W-18){1'b0}}, idx});
    end
  endfunction

  // one synchronised edge chosen by a 2-bit edge select; 10 and 11 take either edge
  function edge_pick;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        `AEC16_EDGE_FALL: edge_pick = fall;
        `AEC16_EDGE_RISE: edge_pick = rise;
        default:          edge_pick = rise | fall;
      endcase
    end
  endfunction

  // one clock event chosen by a 2-bit clock select
  function clk_pick;
    input [1:0] sel;
    input       pin_ev;
    input [2:0] div_ev;
    begin
      case (sel)
        `AEC16_CLK_PIN:  clk_pick = pin_ev;
        `AEC16_CLK_DIV2: clk_pick = div_ev[0];
        `AEC16_CLK_DIV4: clk_pick = div_ev[1];
        default:         clk_pick = div_ev[2];
      endcase
    end
  endfunction

  reg  [7:0]        edge_reg;
  reg  [7:0]        clksel_reg;
  reg  [7:0]        ctrl_reg;
  reg               ovf_reg;
  reg               ovf_armed_reg;
  reg  [7:0]        upper_reg;
  reg  [7:0]        lower_reg;
  reg               irq_en_reg;
  reg               irq_flag_reg;
  reg  [2:0]        presc_reg;
  reg  [ADDR_W-1:0] awaddr_reg;
  reg               aw_full_reg;
  reg  [31:0]       wdata_reg;
  reg  [3:0]        wstrb_reg;
  reg               w_full_reg;
  reg  [7:0]        rd_byte;
  reg               rd_ok;

  wire lo_level;
  wire lo_rise;
  wire lo_fall;
  wire hi_rise;
  wire hi_fall;
  wire gate_level;

  // both pins and the gate pin are asynchronous
  aec16_sync u_lo_sync
  (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (low_event_input_pin_i),
    .level_o (lo_level),
    .rise_o  (lo_rise),
    .fall_o  (lo_fall)
  );

  aec16_sync u_hi_sync
  (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (high_event_input_pin_i),
    .level_o (),
    .rise_o  (hi_rise),
    .fall_o  (hi_fall)
  );

  aec16_sync u_gate_sync
  (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (event_gate_irq_pin_i),
    .level_o (gate_level),
    .rise_o  (),
    .fall_o  ()
  );

  // system clock divider: enable pulses at rate/2, /4, /8
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      presc_reg <= 3'h0;
    else
      presc_reg <= presc_reg + 3'h1;
  end

  wire [2:0] div_ev = {presc_reg == 3'h7,
                       presc_reg[1:0] == 2'h3,
                       presc_reg[0]};

  wire pwm_en   = edge_reg[`AEC16_EDGE_PWM_BIT];
  wire chained  = ~ctrl_reg[`AEC16_CTRL_CH_BIT];
  wire upper_count_enable     = ctrl_reg[`AEC16_CTRL_UPPER_COUNT_ENABLE_BIT];
  wire lower_count_enable     = ctrl_reg[`AEC16_CTRL_LOWER_COUNT_ENABLE_BIT];
  wire upper_reset_control     = ctrl_reg[`AEC16_CTRL_UPPER_RESET_CONTROL_BIT];
  wire lower_reset_control     = ctrl_reg[`AEC16_CTRL_LOWER_RESET_CONTROL_BIT];

  // with pwm halted the gate pin must be high for events to pass
  wire gate_ok  = pwm_en | gate_level;

  wire lo_pin_ev = edge_pick(edge_reg[`AEC16_EDGE_LO_LSB +: 2],
                             lo_rise, lo_fall);
  wire hi_pin_ev = edge_pick(edge_reg[`AEC16_EDGE_HI_LSB +: 2],
                             hi_rise, hi_fall);

  wire lo_src = clk_pick(clksel_reg[`AEC16_CLK_LO_LSB +: 2],
                         lo_pin_ev, div_ev);
  wire lo_tick = lo_src & lower_count_enable & lower_reset_control & gate_ok;
  wire lo_ovf  = lo_tick & (lower_reg == 8'hff);

  wire hi_alone = clk_pick(clksel_reg[`AEC16_CLK_HI_LSB +: 2],
                           hi_pin_ev, div_ev);
  // the chained upper byte sees only lower rollovers, so no gating twice
  wire hi_src  = chained ? lo_ovf : (hi_alone & gate_ok);
  wire hi_tick = hi_src & upper_count_enable & upper_reset_control;
  wire hi_ovf  = hi_tick & (upper_reg == 8'hff);

  // counters
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lower_reg <= `AEC16_RST_BYTE;
      upper_reg <= `AEC16_RST_BYTE;
    end
    else
    begin
      if (!lower_reset_control)
        lower_reg <= `AEC16_RST_BYTE;
      else if (lo_tick)
        lower_reg <= lower_reg + 8'h01;
      if (!upper_reset_control)
        upper_reg <= `AEC16_RST_BYTE;
      else if (hi_tick)
        upper_reg <= upper_reg + 8'h01;
    end
  end

  // pwm output toggles on lower rollover while enabled, held low when halted
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      counter_pwm_o <= 1'b0;
    else if (!pwm_en)
      counter_pwm_o <= 1'b0;
    else if (lo_ovf)
      counter_pwm_o <= ~counter_pwm_o;
  end

  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready_o = ~aw_full_reg & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_full_reg & ~s_axi_bvalid_o;

  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid_o;
  wire wr_lane0 = do_write & wstrb_reg[0];
  wire wr_hit   = hit(awaddr_reg, `AEC16_IDX_EDGE) |
                  hit(awaddr_reg, `AEC16_IDX_CLKSEL) |
                  hit(awaddr_reg, `AEC16_IDX_CTRL) |
                  hit(awaddr_reg, `AEC16_IDX_UPPER) |
                  hit(awaddr_reg, `AEC16_IDX_LOWER) |
                  hit(awaddr_reg, `AEC16_IDX_IRQEN) |
                  hit(awaddr_reg, `AEC16_IDX_IRQFLAG);
  wire wr_ctrl  = wr_lane0 & hit(awaddr_reg, `AEC16_IDX_CTRL);
  wire wr_flag  = wr_lane0 & hit(awaddr_reg, `AEC16_IDX_IRQFLAG);

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awaddr_reg     <= {ADDR_W{1'b0}};
      aw_full_reg    <= 1'b0;
      wdata_reg      <= 32'h0000_0000;
      wstrb_reg      <= 4'h0;
      w_full_reg     <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `AEC16_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        awaddr_reg  <= s_axi_awaddr_i;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
        w_full_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_full_reg    <= 1'b0;
        w_full_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `AEC16_RESP_OKAY : `AEC16_RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // control registers; counters are read-only, writes to them are ignored
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      edge_reg   <= `AEC16_RST_BYTE;
      clksel_reg <= `AEC16_RST_BYTE;
      ctrl_reg   <= `AEC16_RST_BYTE;
      irq_en_reg <= 1'b0;
    end
    else if (wr_lane0)
    begin
      if (hit(awaddr_reg, `AEC16_IDX_EDGE))
        edge_reg <= wdata_reg[7:0] & `AEC16_EDGE_MASK;
      if (hit(awaddr_reg, `AEC16_IDX_CLKSEL))
        clksel_reg <= wdata_reg[7:0] & `AEC16_CLK_MASK;
      if (hit(awaddr_reg, `AEC16_IDX_CTRL))
        ctrl_reg <= wdata_reg[7:0] & `AEC16_CTRL_MASK;
      if (hit(awaddr_reg, `AEC16_IDX_IRQEN))
        irq_en_reg <= wdata_reg[0];
    end
  end

  // overflow flag: a new rollover beats a clear in the same cycle
  wire ovf_seen_one = s_axi_arvalid_i & s_axi_arready_o &
                      hit(s_axi_araddr_i, `AEC16_IDX_CTRL) & ovf_reg;
  wire ovf_clr = wr_ctrl & ovf_armed_reg &
                 ~wdata_reg[`AEC16_CTRL_OVF_BIT];

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ovf_reg       <= 1'b0;
      ovf_armed_reg <= 1'b0;
      irq_flag_reg  <= 1'b0;
    end
    else
    begin
      if (hi_ovf)
        ovf_reg <= 1'b1;
      else if (ovf_clr)
        ovf_reg <= 1'b0;
      if (ovf_seen_one)
        ovf_armed_reg <= 1'b1;
      else if (wr_ctrl)
        ovf_armed_reg <= 1'b0;
      if (hi_ovf)
        irq_flag_reg <= 1'b1;
      else if (wr_flag && !wdata_reg[0])
        irq_flag_reg <= 1'b0;
    end
  end

  assign counter_irq_o = irq_flag_reg & irq_en_reg;

  // axi4-lite read path: one read outstanding, answer one cycle later
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always @*
  begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (hit(s_axi_araddr_i, `AEC16_IDX_EDGE))
      rd_byte = edge_reg;
    else if (hit(s_axi_araddr_i, `AEC16_IDX_CLKSEL))
      rd_byte = clksel_reg;
    else if (hit(s_axi_araddr_i, `AEC16_IDX_CTRL))
      rd_byte = {ovf_reg, 2'b00, ctrl_reg[4:0]};
    else if (hit(s_axi_araddr_i, `AEC16_IDX_UPPER))
      rd_byte = upper_reg;
    else if (hit(s_axi_araddr_i, `AEC16_IDX_LOWER))
      rd_byte = lower_reg;
    else if (hit(s_axi_araddr_i, `AEC16_IDX_IRQEN))
      rd_byte = {7'h00, irq_en_reg};
    else if (hit(s_axi_araddr_i, `AEC16_IDX_IRQFLAG))
      rd_byte = {7'h00, irq_flag_reg};
    else
      rd_ok = 1'b0;
  end

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `AEC16_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h000000, rd_byte};
      s_axi_rresp_o  <= rd_ok ? `AEC16_RESP_OKAY : `AEC16_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // lo_level is kept for visibility of the pin state in simulation
  wire unused_ok = lo_level;
endmodule
`default_nettype wire

// *** aec16_counter_asserts.sv ***
// checker on the register bus and outputs of the event counter
// assumes it is bound onto aec16_counter, one clock, reset active low
`timescale 1ns/10ps
`default_nettype none
`include "aec16_consts.vh"
module aec16_chk
(
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        counter_irq_o,
  input wire logic        counter_pwm_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence both_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  a_w_refused: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o)
    else $error("write channel open during response");
  a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address open during read data");
  a_b_answer: assert property (both_taken |=> ##1 s_axi_bvalid_o)
    else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o)
    else $error("read data late");
  a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped early");
  a_r_byte_only: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o)
    else $error("write response repeated");
  a_resp_code: assert property (s_axi_bvalid_o |->
    s_axi_bresp_o == `AEC16_RESP_OKAY || s_axi_bresp_o == `AEC16_RESP_SLVERR)
    else $error("illegal write response code");
  c_write: cover property (both_taken);
  c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  c_irq: cover property ($rose(counter_irq_o));
  c_pwm: cover property ($rose(counter_pwm_o));
endmodule
`default_nettype wire

// *** aec16_pulse_src.sv ***
// event pulse source standing on one asynchronous event pin
// assumes the pin idles high; timing is free of the system clock
`timescale 1ns/10ps
`default_nettype none
module aec16_pulse_src
(
  output logic pin_o
);
  initial pin_o = 1'b1;
  // 90 ns a level in pulses: over eleven system clocks, so each edge is seen once
  task automatic set_level(input logic lvl);
    #45 pin_o = lvl;
    #45;
  endtask
  task automatic pulses(input int cnt);
    repeat (cnt)
    begin
      set_level(1'b0);
      set_level(1'b1);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench: axi4-lite master, two pulse sources, count model
// assumes aec16_counter with a 20-bit byte address
`timescale 1ns/10ps
`default_nettype none
`include "aec16_consts.vh"
module testbench;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [19:0] awaddr = 20'h0;
  logic [19:0] araddr = 20'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        gate = 1'b1;
  wire         awready, wready, bvalid, arready, rvalid, irq, pwm;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pin_lo, pin_hi;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          lo_m, hi_m, n, t0, ex, vv;
  logic [31:0] v;
  logic [1:0]  r;
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  aec16_counter #(.ADDR_W(20)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .low_event_input_pin_i(pin_lo), .high_event_input_pin_i(pin_hi),
    .event_gate_irq_pin_i(gate), .counter_irq_o(irq), .counter_pwm_o(pwm));
  aec16_pulse_src src_lo (.pin_o(pin_lo));
  aec16_pulse_src src_hi (.pin_o(pin_hi));
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle edge between calls, so no signal is driven twice in a step;
  // handshakes and answers are taken at the rising edge itself
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge mclk_i);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'($urandom), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      r = bresp;
      t++;
    end
    while (!bvalid && t < 64);
    bready <= 1'b0;
    if (!bvalid) n_errors++;
  endtask
  task automatic rd(input logic [15:0] idx);
    int t;
    t = 0;
    @(posedge mclk_i);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      {r, v} = {rresp, rdata};
      t++;
    end
    while (!rvalid && t < 64);
    rready <= 1'b0;
    if (!rvalid) n_errors++;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    rd(idx);
    chk({r, v}, {`AEC16_RESP_OKAY, 24'h0, e});
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    n_errors++;
    complete_run();
  end
  initial
  begin
    n = $urandom(32'ha64574da);
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rdc(`AEC16_IDX_EDGE, `AEC16_RST_BYTE);
    rdc(`AEC16_IDX_CLKSEL, `AEC16_RST_BYTE);
    rdc(`AEC16_IDX_IRQEN, `AEC16_RST_BYTE);
    rdc(`AEC16_IDX_CTRL, 8'h00);
    rdc(`AEC16_IDX_LOWER, 8'h00);
    rdc(`AEC16_IDX_UPPER, 8'h00);
    rdc(`AEC16_IDX_IRQFLAG, 8'h00);
    rd(16'h0100);
    chk({r, v}, {`AEC16_RESP_SLVERR, 32'h0});
    wr(16'h0100, 8'h5a);
    chk({32'h0, r}, {32'h0, `AEC16_RESP_SLVERR});
    // counters held while reset-control is zero, even with events
    wr(`AEC16_IDX_EDGE, 8'h01);
    wr(`AEC16_IDX_CTRL, 8'h0c);
    src_lo.pulses(3);
    rdc(`AEC16_IDX_LOWER, 8'h00);
    n = 256 + $urandom % 64;
    wr(`AEC16_IDX_CTRL, 8'h0f);
    src_lo.pulses(n);
    lo_m = n % 256;
    hi_m = n / 256;
    rdc(`AEC16_IDX_LOWER, lo_m[7:0]);
    rdc(`AEC16_IDX_UPPER, hi_m[7:0]);
    chk({33'h0, pwm}, 34'h1);
    wr(`AEC16_IDX_LOWER, 8'h55);
    rdc(`AEC16_IDX_LOWER, lo_m[7:0]);
    wr(`AEC16_IDX_UPPER, 8'haa);
    rdc(`AEC16_IDX_UPPER, hi_m[7:0]);
    wr(`AEC16_IDX_CTRL, 8'h0b);
    src_lo.pulses(4);
    rdc(`AEC16_IDX_LOWER, lo_m[7:0]);
    @(posedge mclk_i);
    gate <= 1'b0;
    wr(`AEC16_IDX_EDGE, 8'h00);
    wr(`AEC16_IDX_CTRL, 8'h0f);
    src_lo.pulses(2);
    rdc(`AEC16_IDX_LOWER, lo_m[7:0]);
    chk({33'h0, pwm}, 34'h0);
    gate <= 1'b1;
    repeat (4) @(posedge mclk_i);
    src_lo.pulses(2);
    lo_m += 2;
    rdc(`AEC16_IDX_LOWER, lo_m[7:0]);
    for (int e = 0; e < 4; e++)
    begin
      wr(`AEC16_IDX_CTRL, 8'h0e);
      rdc(`AEC16_IDX_LOWER, 8'h00);
      wr(`AEC16_IDX_CTRL, 8'h0f);
      wr(`AEC16_IDX_EDGE, {2'b00, e[1:0], 4'h1});
      src_lo.set_level(1'b0);
      ex = (e != 1);
      rdc(`AEC16_IDX_LOWER, ex[7:0]);
      src_lo.set_level(1'b1);
      ex += (e != 0);
      rdc(`AEC16_IDX_LOWER, ex[7:0]);
    end
    wr(`AEC16_IDX_CTRL, 8'h1c);
    rdc(`AEC16_IDX_UPPER, 8'h00);
    wr(`AEC16_IDX_CLKSEL, 8'h00);
    wr(`AEC16_IDX_CTRL, 8'h1e);
    src_hi.pulses(5);
    rdc(`AEC16_IDX_UPPER, 8'h05);
    wr(`AEC16_IDX_CTRL, 8'h16);
    src_hi.pulses(3);
    rdc(`AEC16_IDX_UPPER, 8'h05);
    // the counter runs five edges short of the window; phase adds one tick
    for (int k = 1; k < 4; k++)
    begin
      wr(`AEC16_IDX_CTRL, 8'h1c);
      wr(`AEC16_IDX_CLKSEL, 8'(k << 2));
      t0 = cyc;
      wr(`AEC16_IDX_CTRL, 8'h1e);
      repeat (40) @(posedge mclk_i);
      rd(`AEC16_IDX_UPPER);
      ex = (cyc - t0 - 5) >> k;
      vv = v[7:0];
      chk({33'h0, vv >= ex && vv <= ex + 1}, 34'h1);
    end
    wr(`AEC16_IDX_CLKSEL, 8'h04);
    wr(`AEC16_IDX_CTRL, 8'h1c);
    wr(`AEC16_IDX_CTRL, 8'h1e);
    repeat (600) @(posedge mclk_i);
    wr(`AEC16_IDX_CTRL, 8'h16);
    rdc(`AEC16_IDX_IRQFLAG, 8'h01);
    chk({33'h0, irq}, 34'h0);
    wr(`AEC16_IDX_IRQEN, 8'h01);
    chk({33'h0, irq}, 34'h1);
    // a write without the low byte lane is answered but changes nothing
    wstrb <= {3'($urandom), 1'b0};
    wr(`AEC16_IDX_IRQEN, 8'h00);
    wstrb <= 4'h1;
    chk({32'h0, r}, {32'h0, `AEC16_RESP_OKAY});
    chk({33'h0, irq}, 34'h1);
    wr(`AEC16_IDX_IRQFLAG, 8'h01);
    rdc(`AEC16_IDX_IRQFLAG, 8'h01);
    wr(`AEC16_IDX_IRQFLAG, 8'h00);
    rdc(`AEC16_IDX_IRQFLAG, 8'h00);
    chk({33'h0, irq}, 34'h0);
    rdc(`AEC16_IDX_CTRL, 8'h96);
    wr(`AEC16_IDX_CTRL, 8'h96);
    wr(`AEC16_IDX_CTRL, 8'h16);
    rdc(`AEC16_IDX_CTRL, 8'h96);
    wr(`AEC16_IDX_CTRL, 8'h16);
    rdc(`AEC16_IDX_CTRL, 8'h16);
    complete_run();
  end
endmodule
bind aec16_counter aec16_chk u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .counter_irq_o(counter_irq_o),
  .counter_pwm_o(counter_pwm_o));
`default_nettype wire
